// file: rtl/pp_pin_ctrl.sv
// Purpose: pad controls of one pin from register bits and overrides.
// Assumes: all inputs come from logic on the core clock, except pad_in.
// Notes:   purely combinational so overrides reach the pad at once.
`timescale 1ns/1ps
`default_nettype none

module pp_pin_ctrl
	import pp_port_pkg::*;
(
	input  wire logic reset_in,        // reset level, forces high impedance
	input  wire logic dir_bit_in,      // pin direction bit
	input  wire logic latch_bit_in,    // pin output latch bit
	input  wire logic pullup_off_in,   // global pull-up disable
	input  wire logic sleep_in,        // clamping sleep level
	input  wire logic ext_int_en_in,   // external interrupt enabled on pin
	input  wire logic spi_force_in,    // force pin to input (spi slave clock)
	input  wire logic pu_ovr_en_in,    // pull-up override enable
	input  wire logic pu_ovr_val_in,   // pull-up override value
	input  wire logic dir_ovr_en_in,   // direction override enable
	input  wire logic dir_ovr_val_in,  // direction override value
	input  wire logic val_ovr_en_in,   // value override enable
	input  wire logic val_ovr_val_in,  // value override value
	input  wire logic ie_ovr_en_in,    // input enable override enable
	input  wire logic ie_ovr_val_in,   // input enable override value
	input  wire logic pad_in,          // level at the pad
	output logic      pad_out,         // level driven onto the pad
	output logic      pad_oe_out,      // pad driver enable
	output logic      pullup_out,      // pull-up enable
	output logic      raw_in_out       // clamped, unsynchronised input
);

	logic dir_eff;
	logic in_enable;

	// direction: override value wins when its enable is set; an spi slave
	// clock pin is forced to input ahead of both
	always_comb begin
		dir_eff = dir_ovr_en_in ? dir_ovr_val_in : dir_bit_in;
		if (spi_force_in) begin
			dir_eff = 1'b0;
		end
		pad_oe_out = dir_eff && !reset_in;
		pad_out    = val_ovr_en_in ? val_ovr_val_in : latch_bit_in;
	end

	// pull-up: follows the override when enabled, else {dir,latch,off}=010;
	// the spi forced input uses the latch bit since dir_eff reads zero
	always_comb begin
		if (pu_ovr_en_in) begin
			pullup_out = pu_ovr_val_in && !reset_in;
		end else begin
			pullup_out = !dir_eff && latch_bit_in && !pullup_off_in && !reset_in;
		end
	end

	// input enable: sleep clamps unless an enabled external interrupt or
	// the override keeps the input alive
	always_comb begin
		if (ie_ovr_en_in) begin
			in_enable = ie_ovr_val_in;
		end else begin
			in_enable = !sleep_in || ext_int_en_in;
		end
		raw_in_out = pad_in && in_enable;
	end

endmodule

`default_nettype wire

// file: rtl/pp_port.sv
// Purpose: one microcontroller i/o port with peripheral overrides.
// Assumes: one core clock, synchronous reset, plain register port.
// Notes:   pad controls are combinational from registers and overrides.
//
// Overview of operation
// - clamp digital input during clamping sleep modes
// - enabled external interrupt pins escape the clamp
// - clamp release gives interrupt edge on wake
// - default pull-up needs dir 0, latch 1, off 0
// - pull-up override enable selects override value
// - direction override enable selects driver source
// - enabled override value sets driver enable unless spi slave forces input
// - driven level is latch without value override
// - value override replaces the latch level
// - toggle override inverts the output latch
// - input enable from sleep state or override
// - input enable override ignores sleep state
// - peripherals get input before the synchroniser
// - global pull-up disable bit kills pull-ups not under override
// - spi slave forces clock pin to input
// - spi master leaves clock pin direction alone
// - forced input pull-up still follows latch
// - direction bit picks output, latch sets level
// - writing one to input register toggles latch
// - reset puts every pin at high impedance
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pp_port_cfg.svh"

module pp_port
	import pp_port_pkg::*;
#(
	parameter int PIN_COUNT   = 8,
	parameter int SPI_CLK_PIN = 7
) (
	input  wire logic                 core_clk_in,           // core clock, 10 MHz
	input  wire logic                 srst_in,               // synchronous reset
	input  wire logic [1:0]           reg_addr_in,           // register index
	input  wire logic [7:0]           reg_wdata_in,          // write data
	input  wire logic                 reg_wr_in,             // write strobe
	input  wire logic                 reg_rd_in,             // read strobe
	output logic      [7:0]           reg_rdata_out,         // read data, next cycle
	input  wire logic                 sleep_in,              // clamping sleep level
	input  wire logic [PIN_COUNT-1:0] ext_int_en_in,         // ext interrupt enabled
	input  wire logic                 spi_enable_in,         // spi enabled
	input  wire logic                 spi_master_in,         // spi is master
	input  wire logic [PIN_COUNT-1:0] pullup_ovr_en_in,      // pull-up override enable
	input  wire logic [PIN_COUNT-1:0] pullup_ovr_val_in,     // pull-up override value
	input  wire logic [PIN_COUNT-1:0] dir_ovr_en_in,         // direction override enable
	input  wire logic [PIN_COUNT-1:0] dir_ovr_val_in,        // direction override value
	input  wire logic [PIN_COUNT-1:0] value_ovr_en_in,       // value override enable
	input  wire logic [PIN_COUNT-1:0] value_ovr_val_in,      // value override value
	input  wire logic [PIN_COUNT-1:0] toggle_ovr_en_in,      // toggle override enable
	input  wire logic [PIN_COUNT-1:0] in_enable_ovr_en_in,   // input enable ovr enable
	input  wire logic [PIN_COUNT-1:0] in_enable_ovr_val_in,  // input enable ovr value
	input  wire logic [PIN_COUNT-1:0] pad_in,                // pad levels
	output logic      [PIN_COUNT-1:0] pad_out,               // pad drive levels
	output logic      [PIN_COUNT-1:0] pad_oe_out,            // pad driver enables
	output logic      [PIN_COUNT-1:0] pad_pullup_out,        // pull-up enables
	output logic      [PIN_COUNT-1:0] alt_func_raw_out,      // unsynchronised input
	output logic      [7:0]           mcu_control_out        // mcu control register
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	// rdata holds until the next read strobe, so a slow reader may
	// still pick it up after the cycle in which it appeared
	typedef struct packed {
		logic [PIN_COUNT-1:0] dir;
		logic [PIN_COUNT-1:0] latch;
		logic [7:0]           mcu;
		logic [7:0]           rdata;
	} pp_state_t;

	pp_state_t            st_q;
	pp_state_t            st_d;
	logic [PIN_COUNT-1:0] sampled;
	logic [PIN_COUNT-1:0] raw_in;
	logic [PIN_COUNT-1:0] spi_force;
	logic [PIN_COUNT-1:0] pin_toggle;
	logic                 pullup_off;
	logic [7:0]           rd_mux;

	// elaboration checks: the register port is only eight bits wide
	if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : g_bad_count
		$error("pp_port: PIN_COUNT must lie in 1..8");
	end
	if (SPI_CLK_PIN < 0 || SPI_CLK_PIN >= PIN_COUNT) begin : g_bad_spi
		$error("pp_port: SPI_CLK_PIN outside the port");
	end

	// ------------------------------------------------------------------
	// register port
	// ------------------------------------------------------------------
	// the global disable is one level shared by every pin, so all
	// pull-ups without an override enable drop in the same cycle
	assign pullup_off = st_q.mcu[`PP_MCU_PUOFF_BIT];

	// a one written to the input register flips the latch, whatever the
	// direction bit holds
	assign pin_toggle = pp_hit(reg_wr_in, reg_addr_in, PP_REG_PIN) ?
			reg_wdata_in[PIN_COUNT-1:0] : {PIN_COUNT{1'b0}};

	// the pin register returns the synchronised level, never the raw pad,
	// so software cannot catch a metastable value
	// read multiplexer; bits above the port width read zero except in the mcu register
	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr_in)
			PP_REG_PIN:   rd_mux[PIN_COUNT-1:0] = sampled;
			PP_REG_DIR:   rd_mux[PIN_COUNT-1:0] = st_q.dir;
			PP_REG_LATCH: rd_mux[PIN_COUNT-1:0] = st_q.latch;
			PP_REG_MCU:   rd_mux = st_q.mcu;
			default:      rd_mux = 8'h00;
		endcase
	end

	// next state: writes, toggles from software and peripherals, read data
	always_comb begin
		st_d = st_q;
		if (pp_hit(reg_wr_in, reg_addr_in, PP_REG_DIR)) begin
			st_d.dir = reg_wdata_in[PIN_COUNT-1:0];
		end
		if (pp_hit(reg_wr_in, reg_addr_in, PP_REG_LATCH)) begin
			st_d.latch = reg_wdata_in[PIN_COUNT-1:0];
		end
		// toggles stack on top of a write so neither is lost
		st_d.latch = st_d.latch ^ pin_toggle ^ toggle_ovr_en_in;
		if (pp_hit(reg_wr_in, reg_addr_in, PP_REG_MCU)) begin
			// read-only bits keep their zero
			st_d.mcu = reg_wdata_in & `PP_MCU_WR_MASK;
		end
		if (reg_rd_in) begin
			st_d.rdata = rd_mux;
		end
	end

	// reset is synchronous here; the pad enables are also gated by the
	// reset level itself, so pins float even with no clock running
	// register the whole state
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			st_q.dir   <= {PIN_COUNT{`PP_PIN_RESET_BIT}};
			st_q.latch <= {PIN_COUNT{`PP_PIN_RESET_BIT}};
			st_q.mcu   <= `PP_MCU_RESET;
			st_q.rdata <= `PP_RDATA_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata_out   = st_q.rdata;
	assign mcu_control_out = st_q.mcu;

	// ------------------------------------------------------------------
	// spi clock pin direction
	// ------------------------------------------------------------------
	// only a slave forces the pin; a master leaves the direction bit in charge
	// the force clears the effective direction, so the pull-up follows
	// the latch and the global disable as on any input
	always_comb begin
		spi_force              = {PIN_COUNT{1'b0}};
		spi_force[SPI_CLK_PIN] = spi_enable_in && !spi_master_in;
	end

	// ------------------------------------------------------------------
	// per pin pad control
	// ------------------------------------------------------------------
	// each pin has its own copy of the control; only reset, sleep and
	// the global disable are shared between them
	// overrides other than the toggle arrive straight from peripheral logic and pass
	// through with no flip-flop, so a peripheral sees its pad change in-cycle
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
			pp_pin_ctrl u_pin (
				.reset_in       (srst_in),
				.dir_bit_in     (st_q.dir[gi]),
				.latch_bit_in   (st_q.latch[gi]),
				.pullup_off_in  (pullup_off),
				.sleep_in       (sleep_in),
				.ext_int_en_in  (ext_int_en_in[gi]),
				.spi_force_in   (spi_force[gi]),
				.pu_ovr_en_in   (pullup_ovr_en_in[gi]),
				.pu_ovr_val_in  (pullup_ovr_val_in[gi]),
				.dir_ovr_en_in  (dir_ovr_en_in[gi]),
				.dir_ovr_val_in (dir_ovr_val_in[gi]),
				.val_ovr_en_in  (value_ovr_en_in[gi]),
				.val_ovr_val_in (value_ovr_val_in[gi]),
				.ie_ovr_en_in   (in_enable_ovr_en_in[gi]),
				.ie_ovr_val_in  (in_enable_ovr_val_in[gi]),
				.pad_in         (pad_in[gi]),
				.pad_out        (pad_out[gi]),
				.pad_oe_out     (pad_oe_out[gi]),
				.pullup_out     (pad_pullup_out[gi]),
				.raw_in_out     (raw_in[gi])
			);
		end
	endgenerate

	// raw input leaves before the synchroniser; users must sync it
	// themselves unless they clock from it. a clamp released on wake
	// rises here and gives edge-sensing interrupt logic its edge
	assign alt_func_raw_out = raw_in;

	// ------------------------------------------------------------------
	// input synchroniser
	// ------------------------------------------------------------------
	// limitation: the pin register lags the pad by two edges, so a pulse
	// shorter than one clock period may never be seen there
	pp_sync #(
		.WIDTH (PIN_COUNT)
	) u_sync (
		.core_clk_in (core_clk_in),
		.srst_in     (srst_in),
		.d_in        (raw_in),
		.q_out       (sampled)
	);

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	// assertions rest while reset is high; the high impedance check at
	// the end is the one that must hold during reset
	// the covers mark the scenarios that the bench has to reach
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (srst_in);

	logic [PIN_COUNT-1:0] exp_dir;
	logic [PIN_COUNT-1:0] exp_clamp;
	logic [PIN_COUNT-1:0] exp_pu_def;

	// independent reference for direction, clamp and default pull-up
	always_comb begin
		exp_dir   = (dir_ovr_en_in & dir_ovr_val_in) | (~dir_ovr_en_in & st_q.dir);
		exp_dir   = exp_dir & ~spi_force;
		exp_clamp = {PIN_COUNT{sleep_in}} & ~ext_int_en_in & ~in_enable_ovr_en_in;
		exp_pu_def = ~exp_dir & st_q.latch & {PIN_COUNT{!pullup_off}};
	end

	// a clamped pin must read low whatever its pad does
	chk_sleep_clamp_low: assert property ((alt_func_raw_out & exp_clamp) == '0)
		else $error("raw input not clamped in sleep");

	chk_ext_int_pass: assert property (
			sleep_in |-> ((alt_func_raw_out ^ pad_in) & ext_int_en_in
			& ~in_enable_ovr_en_in) == '0)
		else $error("interrupt pin clamped in sleep");

	chk_awake_input_pass: assert property (
			!sleep_in |-> ((alt_func_raw_out ^ pad_in) & ~in_enable_ovr_en_in) == '0)
		else $error("awake raw input differs from pad");

	chk_ie_ovr_value: assert property (
			(in_enable_ovr_en_in & (alt_func_raw_out ^ (pad_in & in_enable_ovr_val_in)))
			== '0)
		else $error("input enable override ignored");

	// pull-ups: default table, override, global off and forced spi input
	chk_pullup_default: assert property (
			((pad_pullup_out ^ exp_pu_def) & ~pullup_ovr_en_in) == '0)
		else $error("default pull-up wrong");

	chk_pullup_ovr_val: assert property (
			((pad_pullup_out ^ pullup_ovr_val_in) & pullup_ovr_en_in) == '0)
		else $error("pull-up override not followed");

	chk_pullup_global_off: assert property (
			pullup_off |-> (pad_pullup_out & ~pullup_ovr_en_in) == '0)
		else $error("pull-up on while globally disabled");

	chk_pullup_forced_in: assert property (
			spi_force[SPI_CLK_PIN] && !pullup_ovr_en_in[SPI_CLK_PIN] |->
			pad_pullup_out[SPI_CLK_PIN] == (st_q.latch[SPI_CLK_PIN] && !pullup_off))
		else $error("forced spi input lost its latch pull-up");

	// driver enable and driven level
	chk_driver_enable: assert property (pad_oe_out == exp_dir)
		else $error("driver enable wrong");

	chk_spi_master_dir: assert property (
			spi_enable_in && spi_master_in && !dir_ovr_en_in[SPI_CLK_PIN] |->
			pad_oe_out[SPI_CLK_PIN] == st_q.dir[SPI_CLK_PIN])
		else $error("spi master clock pin ignores its direction bit");

	chk_drive_level: assert property (
			(pad_oe_out & (pad_out ^ ((value_ovr_en_in & value_ovr_val_in)
			| (~value_ovr_en_in & st_q.latch)))) == '0)
		else $error("driven level wrong");

	// register updates, visible one cycle after the strobe
	chk_dir_write: assert property (
			reg_wr_in && reg_addr_in == PP_REG_DIR |=>
			st_q.dir == $past(reg_wdata_in[PIN_COUNT-1:0]))
		else $error("direction write lost");

	chk_latch_write: assert property (
			reg_wr_in && reg_addr_in == PP_REG_LATCH |=> st_q.latch ==
			($past(reg_wdata_in[PIN_COUNT-1:0]) ^ $past(toggle_ovr_en_in)))
		else $error("latch write lost");

	chk_latch_toggle: assert property (
			!reg_wr_in |=> st_q.latch == ($past(st_q.latch) ^ $past(toggle_ovr_en_in)))
		else $error("toggle override did not invert latch");

	chk_pin_write_flip: assert property (
			reg_wr_in && reg_addr_in == PP_REG_PIN |=> st_q.latch ==
			($past(st_q.latch) ^ $past(reg_wdata_in[PIN_COUNT-1:0])
			^ $past(toggle_ovr_en_in)))
		else $error("pin register write did not toggle latch");

	chk_mcu_mask: assert property ((st_q.mcu & ~`PP_MCU_WR_MASK) == 8'h00)
		else $error("read-only mcu control bit set");

	// input path: two stages to the pin register, then the read port
	chk_sync_delay: assert property (
			!$past(srst_in) && !$past(srst_in, 2) |-> sampled == $past(raw_in, 2))
		else $error("sampled input not two cycles behind raw");

	chk_pin_read: assert property (
			reg_rd_in && reg_addr_in == PP_REG_PIN |=>
			reg_rdata_out[PIN_COUNT-1:0] == $past(sampled))
		else $error("pin register read wrong");

	// reset check lives outside the default disable
	chk_reset_hiz: assert property (disable iff (1'b0)
			srst_in |-> pad_oe_out == '0 && pad_pullup_out == '0)
		else $error("pins not high impedance in reset");

	cov_spi_slave_force: cover property (spi_enable_in && !spi_master_in
			&& st_q.dir[SPI_CLK_PIN]);
	cov_sleep_wake_edge: cover property (sleep_in ##1 !sleep_in && pad_in[0]);
	cov_toggle_ovr: cover property (toggle_ovr_en_in != '0);
	cov_read_pins: cover property (reg_rd_in && reg_addr_in == PP_REG_PIN);
	cov_forced_pullup: cover property (spi_force[SPI_CLK_PIN] && pad_pullup_out[SPI_CLK_PIN]);

endmodule

`default_nettype wire

// file: rtl/pp_port_cfg.svh
// Purpose: constants of the port pin override block: register offsets,
//          bit positions and reset values.
// Assumes: included by bare name from the package and the modules.
// Notes:   definitions only, guarded against double inclusion.
`ifndef PP_PORT_CFG_SVH
`define PP_PORT_CFG_SVH

// ----------------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define PP_OFS_PIN      2'h0
`define PP_OFS_DIR      2'h1
`define PP_OFS_LATCH    2'h2
`define PP_OFS_MCU      2'h3

// ----------------------------------------------------------------------
// mcu control register fields
// ----------------------------------------------------------------------
`define PP_MCU_REMAP_BIT    7
`define PP_MCU_PUOFF_BIT    4
`define PP_MCU_RELOC_BIT    1
`define PP_MCU_UNLOCK_BIT   0
`define PP_MCU_WR_MASK      8'h93

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PP_MCU_RESET        8'h00
`define PP_RDATA_RESET      8'h00
`define PP_PIN_RESET_BIT    1'b0

`endif

// file: rtl/pp_port_pkg.sv
// Purpose: types and helpers shared by the port pin override block.
// Assumes: pp_port_cfg.svh supplies the numeric constants.
// Notes:   no state lives here.
`default_nettype none
`include "pp_port_cfg.svh"

package pp_port_pkg;

	// register selector on the plain register port
	typedef enum logic [1:0] {
		PP_REG_PIN   = `PP_OFS_PIN,
		PP_REG_DIR   = `PP_OFS_DIR,
		PP_REG_LATCH = `PP_OFS_LATCH,
		PP_REG_MCU   = `PP_OFS_MCU
	} pp_reg_t;

	// one strobe hitting one register; used for every write decode
	function automatic logic pp_hit(input logic strobe, input logic [1:0] addr,
			input pp_reg_t which);
		pp_hit = strobe && (addr == which);
	endfunction

endpackage

`default_nettype wire

// file: rtl/pp_sync.sv
// Purpose: two flip-flop synchroniser for pin levels.
// Assumes: single clock, synchronous active high reset.
// Notes:   the first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
`include "pp_port_cfg.svh"

module pp_sync
	import pp_port_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk_in, // core clock
	input  wire logic             srst_in,     // synchronous reset
	input  wire logic [WIDTH-1:0] d_in,        // asynchronous levels
	output logic      [WIDTH-1:0] q_out        // synchronised levels
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} pp_sync_state_t;

	pp_sync_state_t st_q;
	pp_sync_state_t st_d;

	if (WIDTH < 1) begin : g_bad_width
		$error("pp_sync: WIDTH must be at least 1");
	end

	// next state: shift the level one stage along
	always_comb begin
		st_d        = st_q;
		st_d.stage1 = d_in;
		st_d.stage2 = st_q.stage1;
	end

	// register the whole state
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			st_q <= '{stage1: {WIDTH{`PP_PIN_RESET_BIT}}, stage2: {WIDTH{`PP_PIN_RESET_BIT}}};
		end else begin
			st_q <= st_d;
		end
	end

	assign q_out = st_q.stage2;

endmodule

`default_nettype wire

// file: tb/pp_periph_model.sv
// Purpose: model of the peripherals that own the pin overrides.
// Assumes: one core clock, synchronous active high reset.
// Notes:   one fixed override set, picked by a select level; a real
//          peripheral would change them with its own state.
`timescale 1ns/1ps
`default_nettype none

module pp_periph_model (
	input  wire logic       core_clk_in,   // core clock
	input  wire logic       srst_in,       // synchronous reset
	input  wire logic       ovr_sel_in,    // 1 = overrides active
	input  wire logic [7:0] toggle_req_in, // latch toggle requests
	input  wire logic [7:0] raw_in,        // unsynchronised pin input
	output logic      [7:0] pu_en_out,     // pull-up override enable
	output logic      [7:0] pu_val_out,    // pull-up override value
	output logic      [7:0] dir_en_out,    // direction override enable
	output logic      [7:0] dir_val_out,   // direction override value
	output logic      [7:0] val_en_out,    // value override enable
	output logic      [7:0] val_val_out,   // value override value
	output logic      [7:0] tog_en_out,    // toggle override enable
	output logic      [7:0] ie_en_out,     // input enable override enable
	output logic      [7:0] ie_val_out,    // input enable override value
	output logic      [7:0] raw_sync_out   // our own synchronised copy
);
	// -------------------------------------------------------------
	// overrides are made here, the port only combines them
	// -------------------------------------------------------------
	logic [7:0] meta_q;

	always_comb begin
		pu_en_out   = ovr_sel_in ? 8'hF0 : 8'h00;
		pu_val_out  = ovr_sel_in ? 8'hCC : 8'h00;
		dir_en_out  = ovr_sel_in ? 8'h0F : 8'h00;
		dir_val_out = ovr_sel_in ? 8'h05 : 8'h00;
		val_en_out  = ovr_sel_in ? 8'h33 : 8'h00;
		val_val_out = ovr_sel_in ? 8'h11 : 8'h00;
		ie_en_out   = ovr_sel_in ? 8'hAA : 8'h00;
		ie_val_out  = ovr_sel_in ? 8'h0A : 8'h00;
		tog_en_out  = toggle_req_in;
	end

	// two stages: the raw input may move at any time
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			meta_q       <= 8'h00;
			raw_sync_out <= 8'h00;
		end else begin
			meta_q       <= raw_in;
			raw_sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench of the port pin override block.
// Assumes: 10 MHz clock, synchronous reset held 20 cycles.
// Notes:   table rows first, then override, mask, toggle, sync, wake and reset cases.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import pp_port_pkg::*;
	typedef struct packed {
		logic       sel;
		logic [7:0] dir, lat, mcu;
		logic       slp;
		logic [7:0] eie;
		logic [1:0] spi;
		logic [7:0] pad, oe, out, pu, raw;
	} pp_tb_row_t;
	// sel dir lat mcu slp eie spi pad | oe out pu raw
	pp_tb_row_t rows [7] = '{
		'{1'b0,8'h0F,8'h3C,8'h00,1'b0,8'h00,2'h0,8'hFF,8'h0F,8'h3C,8'h30,8'hFF},
		'{1'b0,8'h0F,8'h3C,8'h10,1'b0,8'h00,2'h0,8'hFF,8'h0F,8'h3C,8'h00,8'hFF},
		'{1'b0,8'h00,8'hFF,8'h00,1'b1,8'h05,2'h0,8'hFF,8'h00,8'hFF,8'hFF,8'h05},
		'{1'b0,8'hFF,8'hA5,8'h00,1'b0,8'h00,2'h2,8'h5A,8'h7F,8'hA5,8'h80,8'h5A},
		'{1'b0,8'hFF,8'hA5,8'h00,1'b0,8'h00,2'h3,8'h5A,8'hFF,8'hA5,8'h00,8'h5A},
		'{1'b1,8'h00,8'hFF,8'h10,1'b1,8'h00,2'h0,8'hFF,8'h05,8'hDD,8'hC0,8'h0A},
		'{1'b1,8'hFF,8'h00,8'h00,1'b0,8'h00,2'h0,8'h00,8'hF5,8'h11,8'hC0,8'h00}};

	logic       clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, slp = 1'b0, sel = 1'b0;
	logic [1:0] addr = 2'h0, spi = 2'h0;
	logic [7:0] wdata = 8'h00, rdata, eie = 8'h00, pad = 8'h00, tog = 8'h00, got;
	logic [7:0] pu_e, pu_v, dr_e, dr_v, vl_e, vl_v, tg_e, ie_e, ie_v, rsync;
	logic [7:0] oe, pout, pu, raw, mcu;
	int         num_errors = 0, checks_done = 0;

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD %s exp %h got %h", n, e, g); end end

	// -------------------------------------------------------------
	// clock, design and partner
	// -------------------------------------------------------------
	initial begin
		forever #50 clk = ~clk;
	end

	pp_port u_pp_port (.core_clk_in(clk), .srst_in(srst), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.sleep_in(slp), .ext_int_en_in(eie), .spi_enable_in(spi[1]),
		.spi_master_in(spi[0]), .pullup_ovr_en_in(pu_e), .pullup_ovr_val_in(pu_v),
		.dir_ovr_en_in(dr_e), .dir_ovr_val_in(dr_v), .value_ovr_en_in(vl_e),
		.value_ovr_val_in(vl_v), .toggle_ovr_en_in(tg_e), .in_enable_ovr_en_in(ie_e),
		.in_enable_ovr_val_in(ie_v), .pad_in(pad), .pad_out(pout), .pad_oe_out(oe),
		.pad_pullup_out(pu), .alt_func_raw_out(raw), .mcu_control_out(mcu));

	pp_periph_model u_pp_periph_model (.core_clk_in(clk), .srst_in(srst),
		.ovr_sel_in(sel), .toggle_req_in(tog), .raw_in(raw), .pu_en_out(pu_e),
		.pu_val_out(pu_v), .dir_en_out(dr_e), .dir_val_out(dr_v), .val_en_out(vl_e),
		.val_val_out(vl_v), .tog_en_out(tg_e), .ie_en_out(ie_e), .ie_val_out(ie_v),
		.raw_sync_out(rsync));

	// -------------------------------------------------------------
	// register port: one strobe cycle, then a cycle with strobe low
	// -------------------------------------------------------------
	task automatic wr_reg(input pp_reg_t a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data appear in the cycle after the strobe and hold until the next read strobe
	task automatic rd_reg(input pp_reg_t a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic wait_edges(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic report_and_stop;
		if (num_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// run needs well under 1000 cycles; 3000 means a hang
	initial begin
		#(3000 * 100);
		num_errors++;
		report_and_stop;
	end

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		// table of plain configurations
		foreach (rows[i]) begin
			@(posedge clk);
			sel <= rows[i].sel;
			slp <= rows[i].slp;
			eie <= rows[i].eie;
			spi <= rows[i].spi;
			pad <= rows[i].pad;
			wr_reg(PP_REG_DIR, rows[i].dir);
			wr_reg(PP_REG_LATCH, rows[i].lat);
			wr_reg(PP_REG_MCU, rows[i].mcu);
			#1;
			`CHK("oe", rows[i].oe, oe)
			`CHK("out", rows[i].out, pout)
			`CHK("pullup", rows[i].pu, pu)
			`CHK("raw", rows[i].raw, raw)
		end
		// override change reaches pads in the same cycle
		@(posedge clk);
		sel <= 1'b0;
		#1;
		`CHK("oe_now", 8'hFF, oe)
		// reserved mcu bits stay zero
		wr_reg(PP_REG_MCU, 8'hFF);
		rd_reg(PP_REG_MCU, got);
		`CHK("mcu_rd", 8'h93, got)
		`CHK("mcu_out", 8'h93, mcu)
		wr_reg(PP_REG_MCU, 8'h83); // pull-ups stay on; reset must clear the rest
		// pin register write and toggle override both invert the latch
		wr_reg(PP_REG_DIR, 8'h00);
		wr_reg(PP_REG_LATCH, 8'h00);
		wr_reg(PP_REG_PIN, 8'h81);
		@(posedge clk);
		tog <= 8'h02;
		@(posedge clk);
		tog <= 8'h00;
		rd_reg(PP_REG_LATCH, got);
		`CHK("latch_tog", 8'h83, got)
		// raw input moves at once, pin register two edges later
		@(posedge clk);
		pad <= 8'hC3;
		#1;
		`CHK("raw_now", 8'hC3, raw)
		wait_edges(3);
		rd_reg(PP_REG_PIN, got);
		`CHK("pin_rd", 8'hC3, got)
		// clamp then wake: high pin shows a rising edge after sleep
		@(posedge clk);
		pad <= 8'hFF;
		slp <= 1'b1;
		wait_edges(3);
		`CHK("sync_slp", 8'h00, rsync)
		@(posedge clk);
		slp <= 1'b0;
		wait_edges(3);
		`CHK("sync_wake", 8'hFF, rsync)
		// reset tri-states before any edge has seen it
		wr_reg(PP_REG_DIR, 8'h0F);
		wr_reg(PP_REG_LATCH, 8'hF0);
		@(posedge clk);
		srst <= 1'b1;
		#1;
		`CHK("oe_rst", 8'h00, oe)
		`CHK("pu_rst", 8'h00, pu)
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd_reg(PP_REG_DIR, got);
		`CHK("dir_rst", 8'h00, got)
		rd_reg(PP_REG_LATCH, got);
		`CHK("lat_rst", 8'h00, got)
		rd_reg(PP_REG_MCU, got);
		`CHK("mcu_rst", 8'h00, got)
		report_and_stop;
	end
endmodule
`default_nettype wire
